// ### pkg/dot_bit_deinterleave_regs.vh
// constants for the packed dot-product / deinterleave / pair-move / irq-disable datapath
// What this block does
// - low double dot writes signed pair
// - even result: low plus high products
// - odd result: crossed halfword products summed
// - saturation sets status one cycle later
// - status values 0300h, 10h or 20h
// - double dots take four cycles, both units
// - rounding adds 8000h, saturates, keeps upper half
// - even result low half, odd high
// - deinterleave even bits low, odd high
// - deinterleave is two-cycle multiply operation
// - irq disable saves enable, clears both
// - irq disable acts in its own cycle
// - irq disable unconditional single-cycle, no unit
// - pair move: src1 odd, src2 even
// - pair move completes in one cycle
// - single dot has 32 and 64-bit forms
// - single dot sums products, sign-extends pair
// - all 8000h inputs give 8000 0000h
`ifndef DOT_BIT_DEINTERLEAVE_REGS_VH
`define DOT_BIT_DEINTERLEAVE_REGS_VH
`define OP_W 3
`define OP_NONE 3'h0
`define OP_DDOT_LOW 3'h1
`define OP_DDOT_LOW_ROUND 3'h2
`define OP_BIT_DEINTERLEAVE 3'h3
`define OP_PAIR_MOVE 3'h4
`define OP_DOT_PAIR 3'h5
`define OP_IRQ_DISABLE 3'h6
`define DOT_FORM_32 5'h0C
`define DOT_FORM_64 5'h0B
`define CTRL_STAT_RESET 32'h00010100
`define CTRL_STAT_SAT_BIT 9
`define CTRL_STAT_IRQ_EN_BIT 0
`define CTRL_STAT_PREV_IRQ_EN_BIT 1
`define SAT_STAT_RESET 32'h00000000
`define SAT_STAT_SIDE_A_BIT 4
`define SAT_STAT_SIDE_B_BIT 5
`define TASK_STATE_RESET 32'h00000000
`define TASK_STATE_IRQ_EN_BIT 0
`define TASK_STATE_SAVED_IRQ_EN_BIT 1
`define REG_CTRL_STAT 2'h0
`define REG_SAT_STAT 2'h1
`define REG_TASK_STATE 2'h2
`define ROUND_CONST 34'h8000
`define MAX32 32'h7FFFFFFF
`define MIN32 32'h80000000
`define MAX16 16'h7FFF
`define MIN16 16'h8000
`define DOT_LAT 4
`define BIT_DEINTERLEAVE_LAT 2
`endif

// ### hw/dot_sum.v
// one dot-product sum of two signed halfword products, full precision and saturation
`timescale 1ns/1ns
`include "dot_bit_deinterleave_regs.vh"
module dot_sum (
    input wire [15:0] a0,
    input wire [15:0] b0,
    input wire [15:0] a1,
    input wire [15:0] b1,
    input wire round,
    output wire [33:0] sum,
    output wire [31:0] sat_val,
    output wire sat
);
    wire signed [31:0] p0;
    wire signed [31:0] p1;
    wire signed [33:0] full;
    assign p0 = $signed(a0) * $signed(b0);
    assign p1 = $signed(a1) * $signed(b1);
    // 34 bits hold the sum plus the rounding term without wrap
    assign full = {{2{p0[31]}}, p0} + {{2{p1[31]}}, p1} + (round ? `ROUND_CONST : 34'h0);
    assign sum = full;
    assign sat = (full[33:31] != 3'h0) && (full[33:31] != 3'h7);
    assign sat_val = sat ? (full[33] ? `MIN32 : `MAX32) : full[31:0];
endmodule // dot_sum

// ### hw/dot_bit_deinterleave_move_unit.v
// datapath for double/single dot products, deinterleave, pair move and irq disable
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`include "dot_bit_deinterleave_regs.vh"
module dot_bit_deinterleave_move_unit (
    input wire sys_clk,
    input wire rstn,
    input wire issue,
    input wire [2:0] op,
    input wire [4:0] dot_form,
    input wire side_b,
    input wire cond_ok,
    input wire [31:0] src1_e,
    input wire [31:0] src1_o,
    input wire [31:0] src2,
    input wire [1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    output reg wr_e_valid,
    output reg [31:0] wr_e_data,
    output reg wr_o_valid,
    output reg [31:0] wr_o_data,
    output wire irq_enable,
    output wire irq_service_block
);
    reg rst_s1_r;
    reg rst_s2_r;
    wire rst_n;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end
    assign rst_n = rst_s2_r;

    reg [31:0] control_status_reg_r;
    reg [31:0] saturation_status_reg_r;
    reg [31:0] task_state_reg_r;

    // dot-product lane inputs chosen per instruction
    reg [15:0] e_a0, e_b0, e_a1, e_b1, o_a0, o_b0, o_a1, o_b1;
    reg rnd;
    always @* begin
        rnd = (op == `OP_DDOT_LOW_ROUND);
        e_a0 = src1_e[15:0];
        e_b0 = src2[15:0];
        e_a1 = src1_e[31:16];
        e_b1 = src2[31:16];
        o_a0 = src2[31:16];
        o_b0 = src1_o[15:0];
        o_a1 = src2[15:0];
        o_b1 = src1_e[31:16];
        if (op == `OP_DOT_PAIR) begin
            e_a0 = src1_e[15:0];
            e_b0 = src2[15:0];
            e_a1 = src1_e[31:16];
            e_b1 = src2[31:16];
        end
    end

    wire [33:0] e_sum;
    wire [33:0] o_sum;
    wire [31:0] e_sat_val;
    wire [31:0] o_sat_val;
    wire e_sat;
    wire o_sat;
    dot_sum u_even (
        .a0(e_a0), .b0(e_b0), .a1(e_a1), .b1(e_b1), .round(rnd),
        .sum(e_sum), .sat_val(e_sat_val), .sat(e_sat)
    );
    dot_sum u_odd (
        .a0(o_a0), .b0(o_b0), .a1(o_a1), .b1(o_b1), .round(rnd),
        .sum(o_sum), .sat_val(o_sat_val), .sat(o_sat)
    );

    // deinterleave: even bits to low half, odd bits to high half
    reg [31:0] bit_deinterleave_val;
    integer i;
    always @* begin
        bit_deinterleave_val = 32'h0;
        for (i = 0; i < 16; i = i + 1) begin
            bit_deinterleave_val[i] = src2[2 * i];
            bit_deinterleave_val[i + 16] = src2[2 * i + 1];
        end
    end

    // result formed at issue, then held in a short delay line
    reg [31:0] res_e;
    reg [31:0] res_o;
    reg res_we_e;
    reg res_we_o;
    reg res_sat;
    always @* begin
        res_e = 32'h0;
        res_o = 32'h0;
        res_we_e = 1'b0;
        res_we_o = 1'b0;
        res_sat = 1'b0;
        case (op)
            `OP_DDOT_LOW: begin
                res_e = e_sat_val;
                res_o = o_sat_val;
                res_we_e = 1'b1;
                res_we_o = 1'b1;
                res_sat = e_sat | o_sat;
            end
            `OP_DDOT_LOW_ROUND: begin
                // round, clamp, keep upper half: even low, odd high
                res_e = {o_sat_val[31:16], e_sat_val[31:16]};
                res_we_e = 1'b1;
                res_sat = e_sat | o_sat;
            end
            `OP_DOT_PAIR: begin
                // wraps mod 2^32: the all-8000h case reads 8000 0000h
                res_e = e_sum[31:0];
                res_o = {32{e_sum[33]}};
                res_we_e = cond_ok;
                res_we_o = cond_ok && (dot_form == `DOT_FORM_64);
                if (dot_form == `DOT_FORM_64 && e_sum[33:31] == 3'h1) begin
                    res_o = 32'h0;
                end
            end
            `OP_BIT_DEINTERLEAVE: begin
                res_e = bit_deinterleave_val;
                res_we_e = cond_ok;
            end
            default: begin
                res_e = 32'h0;
            end
        endcase
    end

    // stage k of the line holds an instruction issued k cycles ago
    reg [31:0] pe_r [1:`DOT_LAT];
    reg [31:0] po_r [1:`DOT_LAT];
    reg [`DOT_LAT:1] pwe_e_r;
    reg [`DOT_LAT:1] pwo_e_r;
    reg [`DOT_LAT:1] psat_r;
    reg [`DOT_LAT:1] pside_r;
    reg [`DOT_LAT:1] pdeal_r;
    wire is_dot;
    assign is_dot = (op == `OP_DDOT_LOW) || (op == `OP_DDOT_LOW_ROUND) || (op == `OP_DOT_PAIR);
    integer k;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwe_e_r <= {`DOT_LAT{1'b0}};
            pwo_e_r <= {`DOT_LAT{1'b0}};
            psat_r <= {`DOT_LAT{1'b0}};
            pside_r <= {`DOT_LAT{1'b0}};
            pdeal_r <= {`DOT_LAT{1'b0}};
            for (k = 1; k <= `DOT_LAT; k = k + 1) begin
                pe_r[k] <= 32'h0;
                po_r[k] <= 32'h0;
            end
        end else begin
            // stage 1 is E1: both latencies enter here
            pe_r[1] <= res_e;
            po_r[1] <= res_o;
            pwe_e_r[1] <= issue && (is_dot || op == `OP_BIT_DEINTERLEAVE) && res_we_e;
            pwo_e_r[1] <= issue && is_dot && res_we_o;
            psat_r[1] <= issue && res_sat;
            pside_r[1] <= side_b;
            pdeal_r[1] <= issue && (op == `OP_BIT_DEINTERLEAVE);
            for (k = 2; k <= `DOT_LAT; k = k + 1) begin
                pe_r[k] <= pe_r[k - 1];
                po_r[k] <= po_r[k - 1];
                pwe_e_r[k] <= pwe_e_r[k - 1] && !pdeal_r[k - 1];
                pwo_e_r[k] <= pwo_e_r[k - 1];
                psat_r[k] <= psat_r[k - 1];
                pside_r[k] <= pside_r[k - 1];
                pdeal_r[k] <= pdeal_r[k - 1];
            end
        end
    end

    // write port: one result per cycle; dot at E4, bit_deinterleave at E2, pair move next cycle
    wire pm_go;
    assign pm_go = issue && (op == `OP_PAIR_MOVE) && cond_ok;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_e_valid <= 1'b0;
            wr_o_valid <= 1'b0;
            wr_e_data <= 32'h0;
            wr_o_data <= 32'h0;
        end else if (pm_go) begin
            wr_e_valid <= 1'b1;
            wr_o_valid <= 1'b1;
            wr_e_data <= src2;
            wr_o_data <= src1_e;
        end else if (pdeal_r[`BIT_DEINTERLEAVE_LAT - 1] && pwe_e_r[`BIT_DEINTERLEAVE_LAT - 1]) begin
            wr_e_valid <= 1'b1;
            wr_o_valid <= 1'b0;
            wr_e_data <= pe_r[`BIT_DEINTERLEAVE_LAT - 1];
            wr_o_data <= 32'h0;
        end else begin
            wr_e_valid <= pwe_e_r[`DOT_LAT - 1];
            wr_o_valid <= pwo_e_r[`DOT_LAT - 1];
            wr_e_data <= pe_r[`DOT_LAT - 1];
            wr_o_data <= po_r[`DOT_LAT - 1];
        end
    end

    // status registers: hardware sets win over software writes
    wire dis;
    assign dis = issue && (op == `OP_IRQ_DISABLE);
    wire sat_now;
    assign sat_now = psat_r[`DOT_LAT];
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            control_status_reg_r <= `CTRL_STAT_RESET;
            saturation_status_reg_r <= `SAT_STAT_RESET;
            task_state_reg_r <= `TASK_STATE_RESET;
        end else begin
            if (reg_wr && reg_addr == `REG_CTRL_STAT) begin
                control_status_reg_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `REG_SAT_STAT) begin
                saturation_status_reg_r <= reg_wdata;
            end
            if (reg_wr && reg_addr == `REG_TASK_STATE) begin
                task_state_reg_r <= reg_wdata;
            end
            if (sat_now) begin
                control_status_reg_r[`CTRL_STAT_SAT_BIT] <= 1'b1;
                if (pside_r[`DOT_LAT]) begin
                    saturation_status_reg_r[`SAT_STAT_SIDE_B_BIT] <= 1'b1;
                end else begin
                    saturation_status_reg_r[`SAT_STAT_SIDE_A_BIT] <= 1'b1;
                end
            end
            if (dis) begin
                // task-state saved-enable bit takes the old enable, control-status previous-enable bit untouched; software keeps status writes out of this packet
                task_state_reg_r[`TASK_STATE_SAVED_IRQ_EN_BIT] <=
                    task_state_reg_r[`TASK_STATE_IRQ_EN_BIT];
                task_state_reg_r[`TASK_STATE_IRQ_EN_BIT] <= 1'b0;
                control_status_reg_r[`CTRL_STAT_IRQ_EN_BIT] <= 1'b0;
            end
        end
    end

    // enable drops in the disable cycle itself, not a cycle later
    assign irq_enable = control_status_reg_r[`CTRL_STAT_IRQ_EN_BIT] && !dis;
    assign irq_service_block = dis;

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                `REG_CTRL_STAT: reg_rdata <= control_status_reg_r;
                `REG_SAT_STAT: reg_rdata <= saturation_status_reg_r;
                `REG_TASK_STATE: reg_rdata <= task_state_reg_r;
                default: reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule // dot_bit_deinterleave_move_unit

// ### dv/dot_unit_props.sv
// port-level assertions for the dot, deinterleave, pair-move and irq-disable datapath
`timescale 1ns/1ns
`include "dot_bit_deinterleave_regs.vh"
module dot_unit_props (
    input wire sys_clk,
    input wire rstn,
    input wire issue,
    input wire [2:0] op,
    input wire cond_ok,
    input wire [31:0] src1_e,
    input wire [31:0] src2,
    input wire wr_e_valid,
    input wire wr_o_valid,
    input wire [31:0] wr_e_data,
    input wire [31:0] wr_o_data,
    input wire irq_enable,
    input wire irq_service_block
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_move;
        issue && op == `OP_PAIR_MOVE && cond_ok;
    endsequence
    // a later pair move owns the write port, so those cases are excluded
    sequence s_bit_deinterleave;
        issue && op == `OP_BIT_DEINTERLEAVE && cond_ok ##1 !(issue && op == `OP_PAIR_MOVE);
    endsequence
    sequence s_round;
        issue && op == `OP_DDOT_LOW_ROUND ##3 !(issue && op == `OP_PAIR_MOVE);
    endsequence
    sequence s_dot_skip;
        issue && op == `OP_DOT_PAIR && !cond_ok ##1 !issue [*3];
    endsequence
    AST_MOVE: assert property (s_move |=> wr_e_valid && wr_o_valid
        && wr_e_data == $past(src2) && wr_o_data == $past(src1_e)) else $error("pair move");
    AST_BIT_DEINTERLEAVE_LAT: assert property (s_bit_deinterleave |-> ##1 wr_e_valid)
        else $error("deinterleave latency");
    AST_DDOT_LAT: assert property (issue && op == `OP_DDOT_LOW |-> ##4 wr_e_valid && wr_o_valid)
        else $error("double dot latency");
    AST_ROUND_ONE: assert property (s_round |-> ##1 wr_e_valid && !wr_o_valid)
        else $error("rounded result port");
    AST_DOT_SKIP: assert property (s_dot_skip |-> ##1 !wr_e_valid && !wr_o_valid)
        else $error("failed predicate wrote");
    AST_IRQ_OFF_NOW: assert property (issue && op == `OP_IRQ_DISABLE |-> !irq_enable)
        else $error("irq still enabled");
    AST_IRQ_BLOCK_ONLY: assert property (irq_service_block |-> issue && op == `OP_IRQ_DISABLE)
        else $error("stray service block");
    AST_IRQ_OFF_HOLD: assert property (issue && op == `OP_IRQ_DISABLE |=> !irq_enable)
        else $error("enable not cleared");
endmodule // dot_unit_props
bind dot_bit_deinterleave_move_unit dot_unit_props i_props (.sys_clk(sys_clk), .rstn(rstn), .issue(issue),
    .op(op), .cond_ok(cond_ok), .src1_e(src1_e), .src2(src2), .wr_e_valid(wr_e_valid),
    .wr_o_valid(wr_o_valid), .wr_e_data(wr_e_data), .wr_o_data(wr_o_data),
    .irq_enable(irq_enable), .irq_service_block(irq_service_block));

// ### dv/tb.sv
// self-checking bench: directed, random and mid-run reset cases
`timescale 1ns/1ns
`include "dot_bit_deinterleave_regs.vh"
module tb;
    reg sys_clk, rstn, issue, side_b, cond_ok, reg_wr, reg_rd;
    reg [2:0] op;
    reg [4:0] dot_form;
    reg [1:0] reg_addr;
    reg [31:0] src1_e, src1_o, src2, reg_wdata, rv;
    wire [31:0] reg_rdata, wr_e_data, wr_o_data;
    wire wr_e_valid, wr_o_valid, irq_enable, irq_service_block;
    integer fail_count, tests_run, seed, cyc, i, k;
    reg ev [0:15];
    reg ov [0:15];
    reg [31:0] ed [0:15];
    reg [31:0] od [0:15];
    dot_bit_deinterleave_move_unit i_dot_bit_deinterleave_move_unit (.sys_clk(sys_clk), .rstn(rstn), .issue(issue),
        .op(op), .dot_form(dot_form), .side_b(side_b), .cond_ok(cond_ok), .src1_e(src1_e),
        .src1_o(src1_o), .src2(src2), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wr_e_valid(wr_e_valid),
        .wr_e_data(wr_e_data), .wr_o_valid(wr_o_valid), .wr_o_data(wr_o_data),
        .irq_enable(irq_enable), .irq_service_block(irq_service_block));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("MISMATCH %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    function signed [63:0] dsum(input [15:0] a, input [15:0] b, input [15:0] c, input [15:0] d);
        dsum = $signed(a) * $signed(b) + $signed(c) * $signed(d);
    endfunction
    function [31:0] sat(input signed [63:0] s);
        sat = s > 64'sh7FFFFFFF ? 32'h7FFFFFFF : s < -64'sh80000000 ? 32'h80000000 : s[31:0];
    endfunction
    function [15:0] rnd(input signed [63:0] s);
        rnd = sat(s + 64'sh8000) >> 16;
    endfunction
    function [31:0] unzip(input [31:0] x);
        integer j;
        for (j = 0; j < 16; j = j + 1) begin
            unzip[j] = x[2*j];
            unzip[j+16] = x[2*j+1];
        end
    endfunction
    // expectations are filed by the negedge index at which the result must show
    // a suppressed write files nothing, so it cannot cancel an older result due that cycle
    task want(input integer l, input e, input [31:0] de, input o, input [31:0] dd);
        begin
            if (e) begin
                ev[(cyc+l)%16] = 1;
                ed[(cyc+l)%16] = de;
            end
            if (o) begin
                ov[(cyc+l)%16] = 1;
                od[(cyc+l)%16] = dd;
            end
        end
    endtask
    task run(input [2:0] o, input c, input [31:0] e, input [31:0] d, input [31:0] s, input [4:0] f);
        reg signed [63:0] se, so;
        begin
            se = dsum(e[15:0], s[15:0], e[31:16], s[31:16]);
            so = dsum(s[31:16], d[15:0], s[15:0], e[31:16]);
            case (o)
                `OP_DDOT_LOW: want(4, 1, sat(se), 1, sat(so));
                `OP_DDOT_LOW_ROUND: want(4, 1, {rnd(so), rnd(se)}, 0, 0);
                `OP_BIT_DEINTERLEAVE: want(2, c, unzip(s), 0, 0);
                `OP_PAIR_MOVE: want(1, c, s, c, e);
                `OP_DOT_PAIR: want(4, c, se[31:0], c && f == `DOT_FORM_64, {32{se[63]}});
                default: ;
            endcase
            issue <= 1;
            op <= o;
            cond_ok <= c;
            src1_e <= e;
            src1_o <= d;
            src2 <= s;
            dot_form <= f;
            @(posedge sys_clk);
        end
    endtask
    task idle(input integer n);
        begin
            issue <= 0;
            repeat (n) @(posedge sys_clk);
        end
    endtask
    // issue is always low here, since no call comes straight after a run
    task acc(input w, input [1:0] a, input [31:0] d, input [31:0] x);
        begin
            reg_wr <= w;
            reg_rd <= !w;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge sys_clk);
            reg_wr <= 0;
            reg_rd <= 0;
            #1 rv = reg_rdata;
            if (!w) chk(rv, x);
            @(posedge sys_clk);
        end
    endtask
    task do_reset;
        begin
            rstn <= 0;
            repeat (3) @(posedge sys_clk);
            rstn <= 1;
            repeat (3) @(posedge sys_clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask
    always @(negedge sys_clk) begin
        k = cyc % 16;
        chk(wr_e_valid, ev[k]);
        if (ev[k]) chk(wr_e_data, ed[k]);
        chk(wr_o_valid, ov[k]);
        if (ov[k]) chk(wr_o_data, od[k]);
        if (issue && op == `OP_IRQ_DISABLE) chk({irq_enable, irq_service_block}, 1);
        ev[k] = 0;
        ov[k] = 0;
        cyc = cyc + 1;
    end
    initial begin
        sys_clk = 0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count = fail_count + 1;
        report_and_stop;
    end
    initial begin
        {fail_count, tests_run, cyc} = 0;
        seed = 32'h2187E755;
        {rstn, issue, side_b, cond_ok, reg_wr, reg_rd, op, dot_form, reg_addr} = 0;
        {src1_e, src1_o, src2, reg_wdata} = 0;
        for (i = 0; i < 16; i = i + 1) begin
            ev[i] = 0;
            ov[i] = 0;
        end
        do_reset;
        acc(0, `REG_CTRL_STAT, 0, `CTRL_STAT_RESET);
        acc(0, 2'h3, 0, 0);
        run(`OP_DDOT_LOW, 1, 32'h00050003, 32'h00020004, 32'h00070001, 0);
        run(`OP_DDOT_LOW, 1, 32'h46B416BA, 32'hBBAED169, 32'h340BF73B, 0);
        idle(6);
        acc(0, `REG_SAT_STAT, 0, `SAT_STAT_RESET);
        run(`OP_DDOT_LOW, 0, 32'h80005678, 32'h12348000, 32'h80008000, 0);
        idle(3);
        acc(0, `REG_CTRL_STAT, 0, `CTRL_STAT_RESET);
        acc(0, `REG_CTRL_STAT, 0, 32'h00010300);
        acc(0, `REG_SAT_STAT, 0, 32'h00000010);
        run(`OP_DDOT_LOW_ROUND, 0, 32'h80005678, 32'h12348000, 32'h80008001, 0);
        run(`OP_DDOT_LOW_ROUND, 1, 32'h46B416BA, 32'hBBAED169, 32'h340BF73B, 0);
        run(`OP_PAIR_MOVE, 1, 32'h87654321, 0, 32'h12345678, 0);
        run(`OP_PAIR_MOVE, 0, 32'h00070009, 0, 32'h1234ABCD, 0);
        idle(4);
        run(`OP_BIT_DEINTERLEAVE, 1, 0, 0, 32'h9E526E30, 0);
        run(`OP_BIT_DEINTERLEAVE, 0, 0, 0, 32'hFFFF0000, 0);
        run(`OP_DOT_PAIR, 1, 32'h6A321193, 0, 32'hB1746CA4, `DOT_FORM_32);
        run(`OP_DOT_PAIR, 1, 32'h6A321193, 0, 32'hB1746CA4, `DOT_FORM_64);
        run(`OP_DOT_PAIR, 1, 32'h80008000, 0, 32'h80008000, `DOT_FORM_32);
        run(`OP_DOT_PAIR, 1, 32'h80008000, 0, 32'h80008000, `DOT_FORM_64);
        run(`OP_DOT_PAIR, 0, 32'h12343497, 0, 32'h21FF50A7, `DOT_FORM_64);
        idle(5);
        acc(1, `REG_TASK_STATE, 32'h1, 0);
        acc(1, `REG_CTRL_STAT, 32'h00010103, 0);
        run(`OP_IRQ_DISABLE, 0, 0, 0, 0, 0);
        idle(1);
        acc(0, `REG_TASK_STATE, 0, 32'h2);
        acc(0, `REG_CTRL_STAT, 0, 32'h00010102);
        run(`OP_IRQ_DISABLE, 1, 0, 0, 0, 0);
        idle(1);
        acc(0, `REG_TASK_STATE, 0, 0);
        for (i = 0; i < 60; i = i + 1) begin
            side_b <= $random(seed);
            run(3'h1 + {$random(seed)} % 5, $random(seed), $random(seed), $random(seed),
                $random(seed), $random(seed) & 1 ? `DOT_FORM_32 : `DOT_FORM_64);
            idle(4);
        end
        do_reset;
        side_b <= 1;
        run(`OP_DDOT_LOW_ROUND, 0, 32'h80008000, 32'h80008000, 32'h80008001, 0);
        idle(3);
        acc(0, `REG_CTRL_STAT, 0, `CTRL_STAT_RESET);
        acc(0, `REG_CTRL_STAT, 0, 32'h00010300);
        acc(0, `REG_SAT_STAT, 0, 32'h00000020);
        report_and_stop;
    end
endmodule // tb
